// ===== src/rtc_defs.svh
// Offsets, field positions, reset values and timing counts of the RTC supervisor.
// Assumes a 125 MHz ref_clk; included by bare name wherever a number is needed.
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

// Seconds and clock-integrity register.
`define RTC_SEC_ADDR        8'h03
`define RTC_OSF_BIT         7
`define RTC_SEC_TENS_HI     6
`define RTC_SEC_TENS_LO     4
`define RTC_SEC_UNITS_HI    3
`define RTC_SEC_UNITS_LO    0
`define RTC_SEC_TENS_MAX    3'h5
`define RTC_SEC_UNITS_MAX   4'h9

// Supply mode codes (3 bits); 000 is the reset value.
`define RTC_MODE_RESET      3'h0
`define RTC_MODE_STD_ALL    3'h0
`define RTC_MODE_STD_NOBL   3'h1
`define RTC_MODE_STD_NOPF   3'h2
`define RTC_MODE_DIR_ALL    3'h3
`define RTC_MODE_DIR_NOBL   3'h4
`define RTC_MODE_DIR_NOPF   3'h5
`define RTC_MODE_OFF_PF     3'h6
`define RTC_MODE_OFF_NOPF   3'h7

// Clock and recovery hold-off; times in microseconds as printed, cycles derived.
`define RTC_CLK_PERIOD_NS   8
`define RTC_T_REC_MIN_US    15630
`define RTC_T_REC_MAX_US    31250
`define RTC_REC_CYC         ((`RTC_T_REC_MIN_US * 1000 + `RTC_CLK_PERIOD_NS - 1) / `RTC_CLK_PERIOD_NS)
`define RTC_REC_MAX_CYC     ((`RTC_T_REC_MAX_US * 1000) / `RTC_CLK_PERIOD_NS)

// Override entry sequence defaults.
`define RTC_OVR_MIN_CYC     8'h3f
`define RTC_OVR_PULSES      4'h2

`endif

// ===== src/rtc_pkg.sv
// Types shared by the RTC supervisor files.
// Assumes nothing beyond a SystemVerilog compiler.
package rtc_pkg;

   // Override entry sequence detector states.
   typedef enum logic [2:0]
   {
      RTC_OVR_IDLE   = 3'b000,
      RTC_OVR_DATALO = 3'b001,
      RTC_OVR_CLKLO  = 3'b010,
      RTC_OVR_CLKHI  = 3'b011,
      RTC_OVR_DONE   = 3'b100
   } rtc_ovr_st_t;

endpackage

// ===== src/rtc_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes the inputs are quasi-static compared to ref_clk.
`timescale 1ns/100ps
`default_nettype none

module rtc_sync
#(
   parameter int         W   = 1,
   parameter logic [W-1:0] RST = '0
)
(
   input  wire logic         ref_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } rtc_sync_st_t;

   rtc_sync_st_t st_r;
   rtc_sync_st_t st_nxt;

   // A bit only moves once the second and third stage agree; the first stage feeds the second alone.
   always_comb
   begin
      st_nxt    = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int i = 0; i < W; i++)
      begin
         if (st_r.s2[i] == st_r.s3[i])
         begin
            st_nxt.q[i] = st_r.s3[i];
         end
      end
      if (rst)
      begin
         st_nxt.s1 = RST;
         st_nxt.s2 = RST;
         st_nxt.s3 = RST;
         st_nxt.q  = RST;
      end
   end

   // State register.
   always_ff @(posedge ref_clk)
   begin
      st_r <= st_nxt;
   end

   assign q = st_r.q;

endmodule // rtc_sync

`default_nettype wire

// ===== src/rtc_supervisor.sv
// Reset and power-fail supervisor of a real-time clock, with the seconds register.
// Assumes a host register port on ref_clk, analog results arriving as pins, and a one-second tick from logic.
//
// How it works
// - On battery: comparator off, power-fail low.
// - Back on main: release, hold comparator off.
// - Switch-over off, power-fail on: output follows comparator result.
// - Supply source chosen by mode and comparisons.
// - Oscillator stop gives reset and stop flag.
// - Leave reset only when oscillator stable, or by override.
// - Supply below low level means oscillator stopped.
// - Stop flag stays set until host writes 0.
// - Reset held through whole crystal start-up.
// - Power-on defaults: clock out, 24h, detections on.
// - Override needs enable bit plus pin sequence.
// - Recognised sequence releases reset at once.
// - Writing enable 0 ends override mode.
// - Seconds register: flag bit 7, BCD count.
// - Flag reads 1 at power-on; count kept.
// - Switch-over off: battery flag 0, main only.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_defs.svh"

module rtc_supervisor
#(
   parameter int       REC_CYC    = `RTC_REC_CYC,
   parameter logic [7:0] OVR_MIN_CYC = `RTC_OVR_MIN_CYC,
   parameter logic [3:0] OVR_PULSES  = `RTC_OVR_PULSES
)
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       power_fail_sense_in,
   input  wire logic       main_below_bat,
   input  wire logic       main_below_thr,
   input  wire logic       osc_running,
   input  wire logic       osc_stable,
   input  wire logic       supply_low,
   input  wire logic       sda_ce_in,
   input  wire logic       scl_in,
   input  wire logic       one_hz_tick,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       mode_wr,
   input  wire logic [2:0] mode_wdata,
   input  wire logic       ovr_en_wr,
   input  wire logic       ovr_en_wdata,
   input  wire logic       bf_clr,
   output logic      [7:0] reg_rdata,
   output logic            power_fail_out_n_o,
   output logic            power_fail_out_n_oe,
   output logic            backup_supply_out,
   output logic            battery_switch_flag,
   output logic            chip_reset,
   output logic            reset_override_enable,
   output logic            reset_override_mode,
   output logic            square_wave_output_en,
   output logic            hour_24_mode,
   output logic            batt_low_det_en,
   output logic [2:0]      supply_mode
);

   localparam int RCW = $clog2(REC_CYC + 1);

   typedef struct packed
   {
      rtc_pkg::rtc_ovr_st_t ovr_st;
      logic [7:0]           ovr_cnt;
      logic [3:0]           ovr_pulses;
      logic                 ovr_mode;
      logic                 ovr_en;
      logic [2:0]           mode;
      logic                 batt;
      logic                 rec_busy;
      logic [RCW-1:0]       rec_cnt;
      logic                 pfo_oe;
      logic                 bf;
      logic                 osc_stop_flag;
      logic [6:0]           sec;
      logic                 chip_rst;
      logic [7:0]           rdata;
      logic                 clk_en;
      logic                 h24;
      logic                 bl_en;
   } rtc_sup_st_t;

   rtc_sup_st_t st_r;
   rtc_sup_st_t st_nxt;
   logic [7:0]  pins;

   // Every analog result and pin is brought onto ref_clk before use.
   rtc_sync
   #(
      .W   (8),
      .RST (8'h00)
   )
   u_sync
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .d       ({power_fail_sense_in, main_below_bat, main_below_thr, osc_running,
                 osc_stable, supply_low, sda_ce_in, scl_in}),
      .q       (pins)
   );

   wire logic pf_above  = pins[7];
   wire logic lt_bat    = pins[6];
   wire logic lt_thr    = pins[5];
   wire logic osc_run   = pins[4];
   wire logic osc_ok_in = pins[3];
   wire logic vlow      = pins[2];
   wire logic sda_s     = pins[1];
   wire logic scl_s     = pins[0];

   // Increments a two-digit BCD seconds value, wrapping 59 to 00.
   function automatic logic [6:0] bcd_sec_inc(input logic [6:0] s);
      logic [6:0] r;
      r = s;
      if (s[3:0] >= `RTC_SEC_UNITS_MAX)
      begin
         r[3:0] = 4'h0;
         r[6:4] = (s[6:4] >= `RTC_SEC_TENS_MAX) ? 3'h0 : 3'(s[6:4] + 3'h1);
      end
      else
      begin
         r[3:0] = 4'(s[3:0] + 4'h1);
      end
      return r;
   endfunction

   // Decodes whether the switch-over is off, direct or standard, and whether power-fail detection runs.
   function automatic logic mode_sw_off(input logic [2:0] m);
      return (m == `RTC_MODE_OFF_PF) || (m == `RTC_MODE_OFF_NOPF);
   endfunction

   function automatic logic mode_direct(input logic [2:0] m);
      return (m == `RTC_MODE_DIR_ALL) || (m == `RTC_MODE_DIR_NOBL) || (m == `RTC_MODE_DIR_NOPF);
   endfunction

   function automatic logic mode_pf_on(input logic [2:0] m);
      return !((m == `RTC_MODE_STD_NOPF) || (m == `RTC_MODE_DIR_NOPF) || (m == `RTC_MODE_OFF_NOPF));
   endfunction

   // Next-state logic of the whole supervisor.
   always_comb
   begin
      logic osc_ok;
      logic batt_sel;
      logic sec_wr;
      osc_ok   = 1'b0;
      batt_sel = 1'b0;
      sec_wr   = 1'b0;
      st_nxt   = st_r;

      // A low supply stops the oscillator; reset lasts until it runs and is stable.
      osc_ok = osc_run && osc_ok_in && !vlow;

      // Supply source choice.
      if (mode_sw_off(st_r.mode))
      begin
         batt_sel = 1'b0;
      end
      else if (mode_direct(st_r.mode))
      begin
         batt_sel = lt_bat;
      end
      else
      begin
         batt_sel = lt_bat && lt_thr;
      end
      st_nxt.batt = batt_sel;

      // Battery flag rises on each switch to battery; a clear in that same cycle loses.
      if (mode_sw_off(st_r.mode))
      begin
         st_nxt.bf = 1'b0;
      end
      else if (batt_sel && !st_r.batt)
      begin
         st_nxt.bf = 1'b1;
      end
      else if (bf_clr && !st_r.batt)
      begin
         st_nxt.bf = 1'b0;
      end

      // Power-fail output and recovery hold-off of the comparator.
      if (batt_sel)
      begin
         st_nxt.pfo_oe   = 1'b1;
         st_nxt.rec_busy = 1'b0;
         st_nxt.rec_cnt  = '0;
      end
      else if (st_r.batt)
      begin
         st_nxt.pfo_oe   = 1'b0;
         st_nxt.rec_busy = 1'b1;
         st_nxt.rec_cnt  = '0;
      end
      else if (st_r.rec_busy)
      begin
         st_nxt.pfo_oe = 1'b0;
         if (st_r.rec_cnt >= RCW'(REC_CYC - 1))
         begin
            st_nxt.rec_busy = 1'b0;
         end
         else
         begin
            st_nxt.rec_cnt = RCW'(st_r.rec_cnt + 1'b1);
         end
      end
      else if (mode_pf_on(st_r.mode))
      begin
         st_nxt.pfo_oe = !pf_above;
      end
      else
      begin
         st_nxt.pfo_oe = 1'b0;
      end

      // Override entry detector; only watched while held in reset with the enable set.
      case (st_r.ovr_st)
         rtc_pkg::RTC_OVR_IDLE:
         begin
            st_nxt.ovr_cnt    = 8'h00;
            st_nxt.ovr_pulses = 4'h0;
            if (st_r.ovr_en && !osc_ok && !st_r.ovr_mode && !sda_s && scl_s)
            begin
               st_nxt.ovr_st = rtc_pkg::RTC_OVR_DATALO;
            end
         end
         rtc_pkg::RTC_OVR_DATALO:
         begin
            st_nxt.ovr_cnt = (st_r.ovr_cnt == 8'hff) ? st_r.ovr_cnt : 8'(st_r.ovr_cnt + 8'h01);
            if (sda_s)
            begin
               st_nxt.ovr_st = rtc_pkg::RTC_OVR_IDLE;
            end
            else if (!scl_s)
            begin
               st_nxt.ovr_cnt = 8'h00;
               st_nxt.ovr_st  = (st_r.ovr_cnt >= OVR_MIN_CYC) ? rtc_pkg::RTC_OVR_CLKLO
                                                              : rtc_pkg::RTC_OVR_IDLE;
            end
         end
         rtc_pkg::RTC_OVR_CLKLO:
         begin
            st_nxt.ovr_cnt = (st_r.ovr_cnt == 8'hff) ? st_r.ovr_cnt : 8'(st_r.ovr_cnt + 8'h01);
            if (scl_s)
            begin
               st_nxt.ovr_cnt = 8'h00;
               st_nxt.ovr_st  = (st_r.ovr_cnt >= OVR_MIN_CYC) ? rtc_pkg::RTC_OVR_CLKHI
                                                              : rtc_pkg::RTC_OVR_IDLE;
               st_nxt.ovr_pulses = 4'(st_r.ovr_pulses + 4'h1);
            end
         end
         rtc_pkg::RTC_OVR_CLKHI:
         begin
            st_nxt.ovr_cnt = (st_r.ovr_cnt == 8'hff) ? st_r.ovr_cnt : 8'(st_r.ovr_cnt + 8'h01);
            if (st_r.ovr_cnt < OVR_MIN_CYC)
            begin
               if (!scl_s || sda_s)
               begin
                  st_nxt.ovr_st = rtc_pkg::RTC_OVR_IDLE;
               end
            end
            else if (!scl_s && st_r.ovr_pulses < OVR_PULSES)
            begin
               st_nxt.ovr_cnt = 8'h00;
               st_nxt.ovr_st  = rtc_pkg::RTC_OVR_CLKLO;
            end
            else if (sda_s && st_r.ovr_pulses >= OVR_PULSES)
            begin
               st_nxt.ovr_st = rtc_pkg::RTC_OVR_DONE;
            end
            else if (!scl_s)
            begin
               st_nxt.ovr_st = rtc_pkg::RTC_OVR_IDLE;
            end
         end
         rtc_pkg::RTC_OVR_DONE:
         begin
            st_nxt.ovr_mode = st_r.ovr_en;
            st_nxt.ovr_st   = rtc_pkg::RTC_OVR_IDLE;
         end
         default:
         begin
            st_nxt.ovr_st = rtc_pkg::RTC_OVR_IDLE;
         end
      endcase

      // Enable bit writes; a 0 ends override mode and blocks re-entry until set again.
      if (ovr_en_wr)
      begin
         st_nxt.ovr_en = ovr_en_wdata;
         if (!ovr_en_wdata)
         begin
            st_nxt.ovr_mode = 1'b0;
            st_nxt.ovr_st   = rtc_pkg::RTC_OVR_IDLE;
         end
      end

      // Supply mode writes are refused on battery, where the interface is dead.
      if (mode_wr && !st_r.batt)
      begin
         st_nxt.mode = mode_wdata;
      end

      // Internal reset: oscillator stopped and no override in force.
      st_nxt.chip_rst = !osc_ok && !st_nxt.ovr_mode;

      // Seconds register write from the host; refused on battery or in reset.
      sec_wr = reg_wr && (reg_addr == `RTC_SEC_ADDR) && !st_r.batt && !st_r.chip_rst;
      if (sec_wr)
      begin
         st_nxt.sec = reg_wdata[`RTC_SEC_TENS_HI:`RTC_SEC_UNITS_LO];
      end
      else if (one_hz_tick && !st_r.chip_rst)
      begin
         st_nxt.sec = bcd_sec_inc(st_r.sec);
      end

      // Stop flag: any internal reset sets it, and the set beats a host clear in the same cycle.
      if (!osc_ok || st_r.chip_rst)
      begin
         st_nxt.osc_stop_flag = 1'b1;
      end
      else if (sec_wr)
      begin
         st_nxt.osc_stop_flag = reg_wdata[`RTC_OSF_BIT];
      end

      // Read data of the register port; other offsets read as zero.
      if (reg_addr == `RTC_SEC_ADDR)
      begin
         st_nxt.rdata = {st_r.osc_stop_flag, st_r.sec};
      end
      else
      begin
         st_nxt.rdata = 8'h00;
      end

      // Power-on reset leaves the seconds count untouched.
      if (rst)
      begin
         st_nxt.ovr_st     = rtc_pkg::RTC_OVR_IDLE;
         st_nxt.ovr_cnt    = 8'h00;
         st_nxt.ovr_pulses = 4'h0;
         st_nxt.ovr_mode   = 1'b0;
         st_nxt.ovr_en     = 1'b0;
         st_nxt.mode       = `RTC_MODE_RESET;
         st_nxt.batt       = 1'b0;
         st_nxt.rec_busy   = 1'b0;
         st_nxt.rec_cnt    = '0;
         st_nxt.pfo_oe     = 1'b0;
         st_nxt.bf         = 1'b0;
         st_nxt.osc_stop_flag        = 1'b1;
         st_nxt.sec        = st_r.sec;
         st_nxt.chip_rst   = 1'b1;
         st_nxt.rdata      = 8'h00;
         st_nxt.clk_en     = 1'b1;
         st_nxt.h24        = 1'b1;
      end

      // Low-battery detection enable is registered so that the port comes from a flop.
      st_nxt.bl_en = (st_nxt.mode == `RTC_MODE_STD_ALL) || (st_nxt.mode == `RTC_MODE_DIR_ALL);
   end

   // State register; reset is applied through the next-state logic.
   always_ff @(posedge ref_clk)
   begin
      st_r <= st_nxt;
   end

   // Outputs other than the constant-low power_fail_out_n_o come straight from the state register; the open-drain line only ever pulls low.
   assign reg_rdata             = st_r.rdata;
   assign power_fail_out_n_o    = 1'b0;
   assign power_fail_out_n_oe   = st_r.pfo_oe;
   assign backup_supply_out     = st_r.batt;
   assign battery_switch_flag   = st_r.bf;
   assign chip_reset            = st_r.chip_rst;
   assign reset_override_enable = st_r.ovr_en;
   assign reset_override_mode   = st_r.ovr_mode;
   assign square_wave_output_en = st_r.clk_en;
   assign hour_24_mode          = st_r.h24;
   assign batt_low_det_en       = st_r.bl_en;
   assign supply_mode           = st_r.mode;

endmodule // rtc_supervisor

`default_nettype wire

// ===== bench/rtc_supervisor_sva.sv
// Concurrent checks on the ports of the RTC reset and power-fail supervisor.
// Assumes it is bound into rtc_supervisor with the same recovery count.
`timescale 1ns/100ps
`default_nettype none

module rtc_supervisor_sva
#(
   parameter int REC_CYC = 20
)
(
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       main_below_bat,
   input wire logic       osc_running,
   input wire logic       supply_low,
   input wire logic       ovr_en_wr,
   input wire logic       ovr_en_wdata,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   input wire logic       power_fail_out_n_oe,
   input wire logic       backup_supply_out,
   input wire logic       battery_switch_flag,
   input wire logic       chip_reset,
   input wire logic       reset_override_enable,
   input wire logic       reset_override_mode,
   input wire logic       square_wave_output_en,
   input wire logic       hour_24_mode,
   input wire logic       batt_low_det_en,
   input wire logic [2:0] supply_mode
);
   logic [31:0] since_main_r;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   // Cycles on main supply, saturating; it starts full so power-up never counts as a return.
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         since_main_r <= 32'(REC_CYC);
      else if (backup_supply_out)
         since_main_r <= 32'h0;
      else if (since_main_r < 32'(REC_CYC))
         since_main_r <= since_main_r + 32'h1;
   end

   property p_batt_pf; backup_supply_out |-> power_fail_out_n_oe; endproperty
   a_batt_pf: assert property (p_batt_pf) else $error("power fail line released on battery");
   property p_rec_hold; !backup_supply_out && since_main_r < 32'(REC_CYC) |-> !power_fail_out_n_oe; endproperty
   a_rec_hold: assert property (p_rec_hold) else $error("power fail driven during recovery");
   property p_sw_off; $stable(supply_mode) && supply_mode[2:1] == 2'h3 |-> !backup_supply_out && !battery_switch_flag;
   endproperty
   a_sw_off: assert property (p_sw_off) else $error("battery used with switch-over off");
   property p_direct; (supply_mode == 3'h3 && main_below_bat) [*6] |=> backup_supply_out; endproperty
   a_direct: assert property (p_direct) else $error("direct mode did not switch");
   property p_stop_flag; chip_reset && reg_addr == 8'h03 ##1 reg_addr == 8'h03 |=> reg_rdata[7]; endproperty
   a_stop_flag: assert property (p_stop_flag) else $error("stop flag clear during reset");
   property p_osc_rst; (!osc_running && !reset_override_mode) [*6] |=> chip_reset || reset_override_mode; endproperty
   a_osc_rst: assert property (p_osc_rst) else $error("no reset with oscillator stopped");
   property p_low_rst; (supply_low && !reset_override_mode) [*6] |=> chip_reset || reset_override_mode; endproperty
   a_low_rst: assert property (p_low_rst) else $error("no reset with supply low");
   property p_ovr_en; $rose(reset_override_mode) |-> $past(reset_override_enable); endproperty
   a_ovr_en: assert property (p_ovr_en) else $error("override entered while disabled");
   property p_ovr_rel; reset_override_mode |-> !chip_reset; endproperty
   a_ovr_rel: assert property (p_ovr_rel) else $error("override did not release reset");
   property p_ovr_clr; ovr_en_wr && !ovr_en_wdata && !backup_supply_out |=> !reset_override_enable && !reset_override_mode;
   endproperty
   a_ovr_clr: assert property (p_ovr_clr) else $error("override kept after clearing");
   property p_defaults; $fell(rst) |-> square_wave_output_en && hour_24_mode && batt_low_det_en && supply_mode == 3'h0;
   endproperty
   a_defaults: assert property (p_defaults) else $error("wrong state after reset");
endmodule // rtc_supervisor_sva

`default_nettype wire

// ===== bench/rtc_host_model.sv
// Host controller model: drives the serial pins and sees the power-fail line.
// Assumes the pins idle high through pull-ups and a single ref_clk domain.
`timescale 1ns/100ps
`default_nettype none

module rtc_host_model
(
   input  wire logic ref_clk,
   input  wire logic power_fail_out_n_oe,
   output logic      sda_ce_in,
   output logic      scl_in,
   output logic      pf_level
);
   // The power-fail line is open drain with a pull-up, so a released pin reads high.
   assign pf_level = !power_fail_out_n_oe;

   // Both serial pins idle high.
   initial
   begin
      sda_ce_in = 1'b1;
      scl_in    = 1'b1;
   end

   // Data low under high clock, clock pulses, then data rises under high clock.
   // Each phase lasts n cycles; too short a phase is ignored by the device, so n must exceed its minimum.
   task automatic ovr_seq(input int n, input int pulses);
      @(negedge ref_clk);
      sda_ce_in = 1'b0;
      repeat (n) @(negedge ref_clk);
      repeat (pulses)
      begin
         scl_in = 1'b0;
         repeat (n) @(negedge ref_clk);
         scl_in = 1'b1;
         repeat (n) @(negedge ref_clk);
      end
      sda_ce_in = 1'b1;
   endtask
endmodule // rtc_host_model

`default_nettype wire

// ===== bench/rtc_reset_and_power_fail_control_test.sv
// Self-checking bench for the RTC reset and power-fail supervisor.
// Assumes the supervisor, its checker and the host model are compiled before it.
`timescale 1ns/100ps
`default_nettype none

module rtc_reset_and_power_fail_control_test;
   localparam int REC_CYC = 20;
   logic       ref_clk = 1'b0;
   logic       rst = 1'b1;
   logic       power_fail_sense_in = 1'b0;
   logic       main_below_bat = 1'b0;
   logic       main_below_thr = 1'b0;
   logic       osc_running = 1'b0;
   logic       osc_stable = 1'b0;
   logic       supply_low = 1'b0;
   logic       one_hz_tick = 1'b0;
   logic [7:0] reg_addr = 8'h03;
   logic       reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic       mode_wr = 1'b0;
   logic [2:0] mode_wdata = 3'h0;
   logic       ovr_en_wr = 1'b0;
   logic       ovr_en_wdata = 1'b0;
   logic       bf_clr = 1'b0;
   logic [7:0] reg_rdata;
   logic [2:0] supply_mode;
   logic       power_fail_out_n_oe, backup_supply_out, battery_switch_flag, chip_reset;
   logic       reset_override_enable, reset_override_mode, square_wave_output_en, hour_24_mode;
   logic       batt_low_det_en, sda_ce_in, scl_in, pf_level;
   int         bad_count = 0;
   int         n_checks = 0;

   // Short counts keep the run brief; all expectations use the same values.
   rtc_supervisor #(.REC_CYC(REC_CYC), .OVR_MIN_CYC(8'h04), .OVR_PULSES(4'h2)) rtc_supervisor_i
   (
      .ref_clk, .rst, .power_fail_sense_in, .main_below_bat, .main_below_thr, .osc_running, .osc_stable,
      .supply_low, .sda_ce_in, .scl_in, .one_hz_tick, .reg_addr, .reg_wr, .reg_wdata, .mode_wr, .mode_wdata,
      .ovr_en_wr, .ovr_en_wdata, .bf_clr, .reg_rdata, .power_fail_out_n_o(), .power_fail_out_n_oe,
      .backup_supply_out, .battery_switch_flag, .chip_reset, .reset_override_enable, .reset_override_mode,
      .square_wave_output_en, .hour_24_mode, .batt_low_det_en, .supply_mode
   );

   rtc_host_model rtc_host_model_i (.ref_clk, .power_fail_out_n_oe, .sda_ce_in, .scl_in, .pf_level);

   // Clock of 8 ns period.
   always #4 ref_clk = ~ref_clk;

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // Inputs change at the falling edge so the rising edge sees them settled.
   task automatic wr_sec(input logic [7:0] v);
      @(negedge ref_clk);
      reg_addr = 8'h03;
      reg_wr = 1'b1;
      reg_wdata = v;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      cyc(2);
   endtask

   task automatic ovr_wr(input logic v);
      @(negedge ref_clk);
      ovr_en_wr = 1'b1;
      ovr_en_wdata = v;
      @(negedge ref_clk);
      ovr_en_wr = 1'b0;
      cyc(1);
   endtask

   // One second step in BCD, wrapping 59 to 00, leaving the top bit alone.
   function automatic logic [7:0] bcd_next(input logic [7:0] v);
      if (v[3:0] != 4'h9)
         return v + 8'h01;
      if (v[6:4] != 3'h5)
         return {v[7], v[6:4] + 3'h1, 4'h0};
      return {v[7], 7'h00};
   endfunction

   function automatic logic exp_batt(input logic [2:0] m, input logic bb, input logic bt);
      return (m <= 3'h2) ? (bb & bt) : (m <= 3'h5) ? bb : 1'b0;
   endfunction

   function automatic logic det_on(input logic [2:0] m);
      return !(m == 3'h2 || m == 3'h5 || m == 3'h7);
   endfunction

   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Watchdog well beyond the roughly 1700 cycles the sequence needs.
   initial
   begin
      cyc(20000);
      bad_count++;
      complete_run;
   end

   // Main sequence: reset state, override entry, start-up, seconds, stops, then every supply mode.
   initial
   begin
      logic [7:0] v;
      logic       e;
      logic       s;
      void'($urandom(85444));
      cyc(6);
      rst = 1'b0;
      cyc(2);
      check("clock out enable", square_wave_output_en, 8'h01);
      check("24 hour", hour_24_mode, 8'h01);
      check("low detect", batt_low_det_en, 8'h01);
      check("mode", supply_mode, 8'h00);
      check("stop flag", reg_rdata[7], 8'h01);
      check("held in reset", chip_reset, 8'h01);
      reg_addr = 8'h04;
      cyc(2);
      check("unmapped read", reg_rdata, 8'h00);
      reg_addr = 8'h03;
      rtc_host_model_i.ovr_seq(6, 2);
      cyc(4);
      check("override without enable", reset_override_mode, 8'h00);
      ovr_wr(1'b1);
      rtc_host_model_i.ovr_seq(6, 2);
      cyc(6);
      check("override mode", reset_override_mode, 8'h01);
      check("override release", chip_reset, 8'h00);
      ovr_wr(1'b0);
      cyc(1);
      check("override ended", reset_override_mode, 8'h00);
      check("reset again", chip_reset, 8'h01);
      osc_running = 1'b1;
      cyc(8);
      check("running not stable", chip_reset, 8'h01);
      osc_stable = 1'b1;
      cyc(8);
      check("reset left", chip_reset, 8'h00);
      check("stop flag kept", reg_rdata[7], 8'h01);
      for (int i = 0; i < 5; i++)
      begin
         v = (i == 0) ? 8'h59 : {1'b0, 3'($urandom_range(5)), 4'($urandom_range(9))};
         wr_sec(v);
         check("seconds written", reg_rdata, v);
         @(negedge ref_clk);
         one_hz_tick = 1'b1;
         @(negedge ref_clk);
         one_hz_tick = 1'b0;
         cyc(2);
         check("seconds ticked", reg_rdata, bcd_next(v));
      end
      v = bcd_next(v);
      osc_running = 1'b0;
      cyc(8);
      check("stop reset", chip_reset, 8'h01);
      osc_running = 1'b1;
      cyc(8);
      check("stop flag and count", reg_rdata, {1'b1, v[6:0]});
      supply_low = 1'b1;
      cyc(8);
      check("low supply reset", chip_reset, 8'h01);
      supply_low = 1'b0;
      cyc(8);
      check("low supply recovered", chip_reset, 8'h00);
      for (int m = 0; m < 8; m++)
         for (int c = 0; c < 4; c++)
         begin
            s = 1'($urandom_range(1));
            @(negedge ref_clk);
            mode_wr = 1'b1;
            mode_wdata = 3'(m);
            power_fail_sense_in = s;
            @(negedge ref_clk);
            mode_wr = 1'b0;
            main_below_bat = c[0];
            main_below_thr = c[1];
            e = exp_batt(3'(m), c[0], c[1]);
            cyc(8);
            check("mode written", supply_mode, 8'(m));
            check("battery select", backup_supply_out, e);
            check("battery flag", battery_switch_flag, e);
            if (e)
               check("pf on battery", pf_level, 8'h00);
            main_below_bat = 1'b0;
            main_below_thr = 1'b0;
            cyc(8);
            if (e)
               check("pf in recovery", pf_level, 8'h01);
            cyc(REC_CYC + 8);
            check("pf comparator", pf_level, s | !det_on(3'(m)));
            @(negedge ref_clk);
            bf_clr = 1'b1;
            @(negedge ref_clk);
            bf_clr = 1'b0;
         end
      complete_run;
   end
endmodule // rtc_reset_and_power_fail_control_test

bind rtc_supervisor rtc_supervisor_sva #(.REC_CYC(REC_CYC)) rtc_supervisor_sva_i
(
   .ref_clk, .rst, .main_below_bat, .osc_running, .supply_low, .ovr_en_wr, .ovr_en_wdata, .reg_addr, .reg_rdata,
   .power_fail_out_n_oe, .backup_supply_out, .battery_switch_flag, .chip_reset, .reset_override_enable,
   .reset_override_mode, .square_wave_output_en, .hour_24_mode, .batt_low_det_en, .supply_mode
);

`default_nettype wire
